// File: core/tpc_panel.sv
// Test panel control: panel motion, indicators, gated interface, registers.
// Assumes buttons, markers and interface lines synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module tpc_panel #(
    parameter int SKEW_W = 8,
    parameter int IFI_W = 4,
    parameter int IFO_W = 3
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic online_in,
    input wire logic test_btn_in,
    input wire logic wtest_btn_in,
    input wire logic stop_btn_in,
    input wire logic fwd_btn_in,
    input wire logic rev_btn_in,
    input wire logic ffwd_btn_in,
    input wire logic frev_btn_in,
    input wire logic at_bot_in,
    input wire logic at_eot_in,
    input wire logic rw_busy_in,
    input wire logic wr_mode_in,
    input wire logic [SKEW_W-1:0] skew_in,
    input wire logic sel_n_in,
    input wire logic [IFI_W-1:0] ifi_n_in,
    input wire logic [tpc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic test_led_out,
    output logic wtest_led_out,
    output logic lp_led_out,
    output logic eot_led_out,
    output logic data_led_out,
    output logic skew_led_out,
    output logic mot_fwd_out,
    output logic mot_rev_out,
    output logic mot_fast_out,
    output logic wr_ones_out,
    output logic [IFI_W-1:0] ifi_out,
    output logic [IFO_W-1:0] ifo_n_out,
    output logic irq_out
);
    // ****************************************
    // State
    // ****************************************
    tpc_pkg::tpc_motion_t motion_r;
    tpc_pkg::tpc_motion_t motion_nxt;
    logic test_r;
    logic test_nxt;
    logic wtest_r;
    logic wtest_nxt;
    logic panel_act;
    logic moving;
    logic skew_hi;
    logic if_en;
    logic [7:0] gate_rd_r;
    logic [7:0] gate_wr_r;
    logic [tpc_pkg::IRQ_N-1:0] irqs_r;
    logic [tpc_pkg::IRQ_N-1:0] irqs_nxt;
    logic [tpc_pkg::IRQ_N-1:0] irqm_r;
    logic [tpc_pkg::IRQ_N-1:0] ev;
    logic [tpc_pkg::IRQ_N-1:0] w1c;
    logic [31:0] rd_nxt;
    logic req;
    logic acc;

    // Panel usable only in test mode while off line
    assign panel_act = test_r && !online_in;
    assign moving = (motion_r != tpc_pkg::MOT_STOP);

    // ****************************************
    // Test mode and write test
    // ****************************************

    // Entry needs off line and no motion; going on line leaves it
    always_comb
    begin
        test_nxt = test_r;
        if (online_in)
            test_nxt = 1'b0;
        else if (test_btn_in && !moving)
            test_nxt = 1'b1;
        wtest_nxt = wtest_r;
        if (!test_nxt)
            wtest_nxt = 1'b0;
        else if (wtest_btn_in && !moving)
            wtest_nxt = 1'b1;
    end

    // Mode flags
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            test_r <= 1'b0;
            wtest_r <= 1'b0;
        end
        else if (ce_in)
        begin
            test_r <= test_nxt;
            wtest_r <= wtest_nxt;
        end
    end

    assign test_led_out = test_r;
    assign wtest_led_out = wtest_r;

    // ****************************************
    // Tape motion
    // ****************************************

    // Stop wins, then one new selection, then marker ends
    always_comb
    begin
        motion_nxt = motion_r;
        if (!panel_act || stop_btn_in)
            motion_nxt = tpc_pkg::MOT_STOP;
        else if (fwd_btn_in)
            motion_nxt = tpc_pkg::MOT_FWD;
        else if (rev_btn_in)
            motion_nxt = tpc_pkg::MOT_REV;
        else if (ffwd_btn_in)
            motion_nxt = tpc_pkg::MOT_FFWD;
        else if (frev_btn_in)
            motion_nxt = tpc_pkg::MOT_FREV;
        else
        begin
            unique case (motion_r)
                tpc_pkg::MOT_STOP: motion_nxt = tpc_pkg::MOT_STOP;
                tpc_pkg::MOT_FWD: if (at_eot_in) motion_nxt = tpc_pkg::MOT_STOP;
                tpc_pkg::MOT_FFWD: if (at_eot_in) motion_nxt = tpc_pkg::MOT_STOP;
                tpc_pkg::MOT_REV: if (at_bot_in) motion_nxt = tpc_pkg::MOT_STOP;
                tpc_pkg::MOT_FREV: if (at_bot_in) motion_nxt = tpc_pkg::MOT_STOP;
                default: motion_nxt = tpc_pkg::MOT_STOP;
            endcase
        end
    end

    // Motion state and servo commands
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            motion_r <= tpc_pkg::MOT_STOP;
            mot_fwd_out <= 1'b0;
            mot_rev_out <= 1'b0;
            mot_fast_out <= 1'b0;
            wr_ones_out <= 1'b0;
        end
        else if (ce_in)
        begin
            motion_r <= motion_nxt;
            mot_fwd_out <= (motion_nxt == tpc_pkg::MOT_FWD) || (motion_nxt == tpc_pkg::MOT_FFWD);
            mot_rev_out <= (motion_nxt == tpc_pkg::MOT_REV) || (motion_nxt == tpc_pkg::MOT_FREV);
            mot_fast_out <= (motion_nxt == tpc_pkg::MOT_FFWD) || (motion_nxt == tpc_pkg::MOT_FREV);
            wr_ones_out <= wtest_nxt && (motion_nxt == tpc_pkg::MOT_FWD);
        end
    end

    // ****************************************
    // Indicators
    // ****************************************

    // Gate picked by read or write mode
    assign skew_hi = skew_in > (wr_mode_in ? gate_wr_r : gate_rd_r);

    // Lamps follow their sources one cycle later
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            lp_led_out <= 1'b0;
            eot_led_out <= 1'b0;
            data_led_out <= 1'b0;
            skew_led_out <= 1'b0;
        end
        else if (ce_in)
        begin
            lp_led_out <= at_bot_in;
            eot_led_out <= at_eot_in;
            data_led_out <= rw_busy_in;
            skew_led_out <= skew_hi;
        end
    end

    // ****************************************
    // Interface gating
    // ****************************************

    // Low is true, so an open line reads false
    assign if_en = online_in && !sel_n_in;

    // Inputs honoured and outputs driven only on line and selected
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ifi_out <= '0;
            ifo_n_out <= '1;
        end
        else if (ce_in)
        begin
            ifi_out <= if_en ? ~ifi_n_in : '0;
            ifo_n_out <= if_en ? ~{at_eot_in, at_bot_in, moving} : '1;
        end
    end

    // ****************************************
    // Avalon-MM slave
    // ****************************************

    // One wait cycle, then a single accept cycle
    assign req = avs_read || avs_write;
    assign acc = req && !avs_waitrequest;

    // Read mux; unmapped words read zero
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        unique case (avs_address)
            tpc_pkg::REG_GATE: rd_nxt = {16'h0000, gate_wr_r, gate_rd_r};
            tpc_pkg::REG_STAT: rd_nxt = {21'h000000, skew_led_out, if_en, online_in, at_eot_in,
                at_bot_in, wtest_r, test_r, 1'b0, motion_r};
            tpc_pkg::REG_IRQS: rd_nxt = {29'h00000000, irqs_r};
            tpc_pkg::REG_IRQM: rd_nxt = {29'h00000000, irqm_r};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Handshake and read data
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else if (ce_in)
        begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (avs_read && avs_waitrequest)
                avs_readdata <= rd_nxt;
        end
    end

    // Writable settings
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            gate_rd_r <= tpc_pkg::GATE_RD_RST;
            gate_wr_r <= tpc_pkg::GATE_WR_RST;
            irqm_r <= tpc_pkg::IRQM_RST;
        end
        else if (ce_in && acc && avs_write)
        begin
            if (avs_address == tpc_pkg::REG_GATE)
            begin
                gate_rd_r <= avs_writedata[tpc_pkg::GATE_RD_LSB +: 8];
                gate_wr_r <= avs_writedata[tpc_pkg::GATE_WR_LSB +: 8];
            end
            if (avs_address == tpc_pkg::REG_IRQM)
                irqm_r <= avs_writedata[tpc_pkg::IRQ_N-1:0];
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************

    // Events: test mode entry, marker stop, skew lamp rising
    always_comb
    begin
        ev = '0;
        ev[tpc_pkg::IRQ_TEST] = test_nxt && !test_r;
        ev[tpc_pkg::IRQ_MARK] = moving && panel_act && !stop_btn_in
            && (motion_nxt == tpc_pkg::MOT_STOP);
        ev[tpc_pkg::IRQ_SKEW] = skew_hi && !skew_led_out;
        w1c = (acc && avs_write && avs_address == tpc_pkg::REG_IRQS) ?
            avs_writedata[tpc_pkg::IRQ_N-1:0] : '0;
        irqs_nxt = (irqs_r & ~w1c) | ev; // Set beats clear
    end

    // Sticky status and level interrupt
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            irqs_r <= '0;
            irq_out <= 1'b0;
        end
        else if (ce_in)
        begin
            irqs_r <= irqs_nxt;
            irq_out <= |(irqs_nxt & irqm_r);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************

    AST_TEST_ENTRY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(test_r) |-> $past(!online_in && motion_r == tpc_pkg::MOT_STOP))
        else $error("test mode entered while on line or moving");

    AST_TEST_LED_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && online_in) |=> !test_led_out)
        else $error("test lamp lit while on line");

    AST_WRITE_ONES: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_ones_out |-> (wtest_led_out && mot_fwd_out && !mot_fast_out))
        else $error("ones written outside forward run write test");

    AST_STOP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && stop_btn_in) |=> (!mot_fwd_out && !mot_rev_out && motion_r == tpc_pkg::MOT_STOP))
        else $error("motion continued after stop");

    AST_FWD_EOT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && at_eot_in && !fwd_btn_in && !ffwd_btn_in && mot_fwd_out) |=> !mot_fwd_out)
        else $error("forward motion past end marker");

    AST_REV_BOT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && at_bot_in && !rev_btn_in && !frev_btn_in && mot_rev_out) |=> !mot_rev_out)
        else $error("reverse motion past load point");

    AST_FAST_REV: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (motion_r == tpc_pkg::MOT_FREV) |-> (mot_rev_out && mot_fast_out && !mot_fwd_out))
        else $error("fast reverse not at rewind rate");

    AST_LOAD_LED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && rst_n_in) |=> (lp_led_out == $past(at_bot_in)) && (eot_led_out == $past(at_eot_in)))
        else $error("marker lamps wrong");

    AST_SKEW_LED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && !wr_mode_in && skew_in > gate_rd_r) |=> skew_led_out)
        else $error("skew lamp not lit over read gate");

    AST_IF_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && !(online_in && !sel_n_in)) |=> ((&ifo_n_out) && ifi_out == '0))
        else $error("interface active while off line or deselected");

    AST_BUS_ACK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("waitrequest not released after one cycle");

endmodule
`default_nettype wire

// File: core/tpc_pkg.sv
// Shared constants for the tape test panel controller.
// Assumes a single 25 MHz clock and word-addressed Avalon-MM access.
package tpc_pkg;

    // ****************************************
    // Register map (word index)
    // ****************************************
    localparam int ADDR_W = 3;
    localparam logic [2:0] REG_GATE = 3'h0;
    localparam logic [2:0] REG_STAT = 3'h1;
    localparam logic [2:0] REG_IRQS = 3'h2;
    localparam logic [2:0] REG_IRQM = 3'h3;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int GATE_RD_LSB = 0;
    localparam int GATE_WR_LSB = 8;
    localparam logic [7:0] GATE_RD_RST = 8'h10;
    localparam logic [7:0] GATE_WR_RST = 8'h10;
    localparam int IRQ_TEST = 0;
    localparam int IRQ_MARK = 1;
    localparam int IRQ_SKEW = 2;
    localparam int IRQ_N = 3;
    localparam logic [2:0] IRQM_RST = 3'h0;

    // ****************************************
    // Tape motion modes
    // ****************************************
    typedef enum logic [2:0] {
        MOT_STOP = 3'b000,
        MOT_FWD = 3'b001,
        MOT_REV = 3'b010,
        MOT_FFWD = 3'b011,
        MOT_FREV = 3'b100
    } tpc_motion_t;

endpackage

// File: tb/test_tape_test_panel_control.sv
// Self-checking bench for the tape test panel controller.
// Assumes the tape model drives the markers; clock enable is dropped once.
`timescale 1ns/1ps
`default_nettype none
module test_tape_test_panel_control;
    logic clk_in, rst_n_in, ce, online, rw_busy, wr_mode, sel_n, rd, wr, wait_r, irq;
    logic [6:0] btn;
    logic [7:0] skew;
    logic [3:0] ifi_n, ifi;
    logic [2:0] addr, ifo_n;
    logic [31:0] wdata, rdata, got;
    logic tled, wled, lpl, eotl, dled, sled, mf, mr, mfast, ones, bot, eot;
    int mismatches, n_compared;
    // ********
    // Design and tape model
    // ********
    tpc_panel i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .online_in(online),
        .test_btn_in(btn[0]), .wtest_btn_in(btn[1]), .stop_btn_in(btn[2]), .fwd_btn_in(btn[3]),
        .rev_btn_in(btn[4]), .ffwd_btn_in(btn[5]), .frev_btn_in(btn[6]), .at_bot_in(bot),
        .at_eot_in(eot), .rw_busy_in(rw_busy), .wr_mode_in(wr_mode), .skew_in(skew),
        .sel_n_in(sel_n), .ifi_n_in(ifi_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_r),
        .test_led_out(tled), .wtest_led_out(wled), .lp_led_out(lpl), .eot_led_out(eotl),
        .data_led_out(dled), .skew_led_out(sled), .mot_fwd_out(mf), .mot_rev_out(mr),
        .mot_fast_out(mfast), .wr_ones_out(ones), .ifi_out(ifi), .ifo_n_out(ifo_n), .irq_out(irq));
    tpc_tape_model i_tape (.clk_in(clk_in), .rst_n_in(rst_n_in), .mot_fwd_in(mf),
        .mot_rev_in(mr), .mot_fast_in(mfast), .at_bot_out(bot), .at_eot_out(eot));
    // Clock at 25 MHz
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bus access: hold request until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_in);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        while (wait_r !== 1'b0)
            @(posedge clk_in);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(got, e);
    endtask
    task automatic settle();
        @(posedge clk_in);
        @(negedge clk_in);
    endtask
    // One-cycle button press, outputs inspected once settled
    task press(input int i);
        @(posedge clk_in);
        btn[i] <= 1'b1;
        @(posedge clk_in);
        btn[i] <= 1'b0;
        @(negedge clk_in);
    endtask
    task automatic wait_stop();
        for (int k = 0; k < 200 && (mf !== 1'b0 || mr !== 1'b0); k++)
            @(negedge clk_in);
        settle();
    endtask
    task skew_chk(input logic m, input logic [7:0] s, input logic e);
        @(posedge clk_in);
        wr_mode <= m;
        skew <= s;
        settle();
        chk(sled, e);
    endtask
    task automatic finish_test();
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        finish_test();
    end
    // ********
    // Test sequence
    // ********
    initial
    begin
        {rst_n_in, online, rw_busy, wr_mode, rd, wr, btn, skew, addr, wdata} = '0;
        sel_n = 1'b1;
        ce = 1'b1;
        ifi_n = 4'hF;
        n_compared = 0;
        mismatches = 0;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        settle();
        chk(ifo_n, 3'b111);
        rdchk(3'h0, 32'h1010);
        rdchk(3'h3, 32'h0);
        rdchk(3'h5, 32'h0);
        // Test button refused while on line
        online <= 1'b1;
        press(0);
        chk(tled, 1'b0);
        @(posedge clk_in);
        online <= 1'b0;
        press(0);
        chk(tled, 1'b1);
        rdchk(3'h2, 32'h1);
        bus(1'b1, 3'h3, 32'h3);
        settle();
        chk(irq, 1'b1);
        bus(1'b1, 3'h2, 32'h1);
        settle();
        chk(irq, 1'b0);
        // Write test, then forward run to the end marker
        press(1);
        chk({wled, ones}, 2'b10);
        press(3);
        chk({mf, mfast, ones}, 3'b101);
        wait_stop();
        chk({eot, eotl, ones}, 3'b110);
        chk(irq, 1'b1);
        rdchk(3'h2, 32'h2);
        bus(1'b1, 3'h2, 32'h2);
        press(4);
        chk({mf, mr, mfast}, 3'b010);
        wait_stop();
        chk({bot, lpl, eotl}, 3'b110);
        // Fast forward, cancelled by reverse, then stopped
        press(5);
        chk({mf, mr, mfast, ones}, 4'b1010);
        press(4);
        chk({mf, mr, mfast}, 3'b010);
        press(2);
        chk({mf, mr}, 2'b00);
        press(6);
        chk({mf, mr, mfast}, 3'b011);
        wait_stop();
        chk({bot, lpl}, 2'b11);
        @(posedge clk_in);
        rw_busy <= 1'b1;
        settle();
        chk(dled, 1'b1);
        @(posedge clk_in);
        rw_busy <= 1'b0;
        // Skew gate: read gate 0x10, write gate set to 0x40
        skew_chk(1'b0, 8'h10, 1'b0);
        chk(dled, 1'b0);
        skew_chk(1'b0, 8'h11, 1'b1);
        bus(1'b1, 3'h0, 32'h4010);
        skew_chk(1'b1, 8'h40, 1'b0);
        skew_chk(1'b1, 8'h41, 1'b1);
        // Interface gating on line and selected
        @(posedge clk_in);
        online <= 1'b1;
        sel_n <= 1'b0;
        ifi_n <= 4'hA;
        settle();
        settle();
        chk(ifi, 4'h5);
        chk(ifo_n, 3'b101);
        chk(tled, 1'b0);
        // Two microsecond pulse on one line, as a controller sends it
        @(posedge clk_in);
        ifi_n <= 4'hE;
        repeat (25) @(negedge clk_in);
        chk(ifi, 4'h1);
        repeat (26) @(posedge clk_in);
        ifi_n <= 4'hF;
        settle();
        chk(ifi, 4'h0);
        // Clock enable low freezes the gated inputs
        @(posedge clk_in);
        ce <= 1'b0;
        ifi_n <= 4'hA;
        settle();
        chk(ifi, 4'h0);
        @(posedge clk_in);
        ce <= 1'b1;
        settle();
        chk(ifi, 4'h5);
        @(posedge clk_in);
        sel_n <= 1'b1;
        ifi_n <= 4'h0;
        settle();
        settle();
        chk(ifi, 4'h0);
        chk(ifo_n, 3'b111);
        finish_test();
    end
endmodule
`default_nettype wire

// File: tb/tpc_tape_model.sv
// Tape position model standing in for the transport servos and marker sensors.
// Assumes panel motion commands; one step a cycle, four when fast.
`timescale 1ns/1ps
`default_nettype none
module tpc_tape_model #(
    parameter int LEN = 40
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic mot_fwd_in,
    input wire logic mot_rev_in,
    input wire logic mot_fast_in,
    output logic at_bot_out,
    output logic at_eot_out
);
    // ********
    // Tape position
    // ********
    int pos_r;
    int step;
    assign step = mot_fast_in ? 4 : 1;
    // Tape cannot travel past either marker
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pos_r <= 0;
        else if (mot_fwd_in)
            pos_r <= (pos_r + step > LEN) ? LEN : pos_r + step;
        else if (mot_rev_in)
            pos_r <= (pos_r < step) ? 0 : pos_r - step;
    end
    // Marker sensors
    assign at_bot_out = (pos_r == 0);
    assign at_eot_out = (pos_r == LEN);
endmodule
`default_nettype wire
